/* hdl/adc_pkg.sv */
// ==========================================================================
// Register map and field layout of the converter control group.
package adc_pkg;

  localparam logic [7:0] POWER_CTRL_OFS    = 8'h02;
  localparam logic [7:0] MUTE_REQ_OFS      = 8'h03;
  localparam logic [7:0] PLL_CTRL_OFS      = 8'h04;
  localparam logic [7:0] PAGE_INC_OFS      = 8'h06;
  localparam logic [7:0] FILT_OUT_OFS      = 8'h07;
  localparam logic [7:0] PIN_DIR_OFS       = 8'h08;

  localparam int POWERDOWN_BIT   = 0;
  localparam int STANDBY_BIT     = 4;
  localparam int LEFT_MUTE_BIT   = 4;
  localparam int RIGHT_MUTE_BIT  = 0;
  localparam int PLL_ENABLE_BIT  = 0;
  localparam int PLL_UNLOCK_BIT  = 4;
  localparam int PAGE_INC_BIT    = 3;
  localparam int DEEMPH_BIT      = 4;
  localparam int SOURCE_SEL_BIT  = 0;
  localparam int PIN_DIR_BIT     = 5;
  localparam int MUTE_FWD_BIT    = 4;

  localparam logic POWERDOWN_RST  = 1'b0;
  localparam logic STANDBY_RST    = 1'b0;
  localparam logic MUTE_RST       = 1'b0;
  localparam logic PLL_ENABLE_RST = 1'b1;
  localparam logic PAGE_INC_RST   = 1'b0;
  localparam logic DEEMPH_RST     = 1'b0;
  localparam logic SOURCE_SEL_RST = 1'b1;
  localparam logic PIN_DIR_RST    = 1'b0;
  localparam logic MUTE_FWD_RST   = 1'b0;

  // Page geometry for auto-increment addressing.
  localparam logic [7:0] PAGE_LAST_LOC    = 8'h7f;
  localparam logic [7:0] NEXT_PAGE_START  = 8'h08;

  // Ramp step period for soft mute.
  localparam int RAMP_STEP_NS     = 100;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum { PWR_RUN, PWR_STANDBY, PWR_DOWN } adc_power_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adc_bus_type;

  typedef struct packed {
    logic powerdown;
    logic standby;
    logic left_mute;
    logic right_mute;
    logic pll_enable;
    logic page_inc_dis;
    logic deemph;
    logic source_sel;
    logic pin_dir;
    logic mute_fwd;
  } adc_ctrl_type;

endpackage : adc_pkg

/* hdl/adc_ctrl_regs.sv */
`timescale 1ns/1ps
// Contract
// - Powerdown: lowest power, charge pump off
// - Powerdown wins over standby when both set
// - Standby: most off, pump and digital on
// - Left mute ramps volume down, up smoothly
// - Right mute ramps volume down, up smoothly
// - Unlock flag zero when locked, one disabled
// - PLL enable resets one; zero selects pin
// - Page wrap: next page 8th, or 0
// - Bit four enables de-emphasis filter
// - Source select: zero post, one pre
// - Bit five drives serial output pin
// - Bit four forwards mute to power stage
module adc_ctrl_regs #(
  parameter int VOL_W = 8
) (
  input  wire logic                MCLK,          // Master clock, 100 MHz.
  input  wire logic                NRST,          // Asynchronous reset, active low.
  input  wire adc_pkg::adc_bus_type BUS,          // Host register access.
  output logic [7:0]               RDATA,         // Read data, registered.
  input  wire logic                PLL_LOCKED,    // Lock indication from the PLL.
  input  wire logic [7:0]          BOOK,          // Current book of the host port.
  input  wire logic [7:0]          PAGE,          // Current page of the host port.
  input  wire logic [7:0]          ADDR_CUR,      // Current location of the host port.
  output logic [7:0]               NEXT_PAGE,     // Page after auto-increment.
  output logic [7:0]               NEXT_ADDR,     // Location after auto-increment.
  output logic                     POWERDOWN,     // Lowest-power state active.
  output logic                     STANDBY,       // System standby active.
  output logic                     PUMP_ON,       // Charge pump supply on.
  output logic                     ANALOG_ON,     // Subsystems powered.
  output logic [VOL_W-1:0]         VOL_LEFT,      // Left gain scale.
  output logic [VOL_W-1:0]         VOL_RIGHT,     // Right gain scale.
  output logic                     PLL_ON,        // Internal PLL running.
  output logic                     CLK_FROM_PIN,  // Master clock taken from pin.
  output logic                     DEEMPH_ON,     // De-emphasis filter in path.
  input  wire logic                PRE_AUDIO,     // Pre-processing audio bit.
  input  wire logic                POST_AUDIO,    // Post-processing audio bit.
  input  wire logic                SERIAL_DATA_OUTPUT_PIN_I,  // Serial output pin input.
  output logic                     SERIAL_DATA_OUTPUT_PIN_O,  // Serial output pin drive.
  output logic                     SERIAL_DATA_OUTPUT_PIN_OE, // Serial output pin enable.
  output logic                     SERIAL_DATA_OUTPUT_PIN_IN, // Pin level when used as input.
  input  wire logic                MUTE_CTRL,     // Converter mute control.
  output logic                     AMP_MUTE       // Mute forwarded to power stage.
);

  // ========================================================================
  // Control registers
  adc_pkg::adc_ctrl_type ctrl_reg;
  adc_pkg::adc_ctrl_type ctrl_next;
  logic [7:0]            rdata_reg;
  logic [7:0]            rdata_next;

  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (BUS.wr)
    begin
      case (BUS.addr)
        adc_pkg::POWER_CTRL_OFS:
        begin
          ctrl_next.powerdown = BUS.wdata[adc_pkg::POWERDOWN_BIT];
          ctrl_next.standby   = BUS.wdata[adc_pkg::STANDBY_BIT];
        end
        adc_pkg::MUTE_REQ_OFS:
        begin
          ctrl_next.left_mute  = BUS.wdata[adc_pkg::LEFT_MUTE_BIT];
          ctrl_next.right_mute = BUS.wdata[adc_pkg::RIGHT_MUTE_BIT];
        end
        adc_pkg::PLL_CTRL_OFS:
          ctrl_next.pll_enable = BUS.wdata[adc_pkg::PLL_ENABLE_BIT];
        adc_pkg::PAGE_INC_OFS:
          ctrl_next.page_inc_dis = BUS.wdata[adc_pkg::PAGE_INC_BIT];
        adc_pkg::FILT_OUT_OFS:
        begin
          ctrl_next.deemph     = BUS.wdata[adc_pkg::DEEMPH_BIT];
          ctrl_next.source_sel = BUS.wdata[adc_pkg::SOURCE_SEL_BIT];
        end
        adc_pkg::PIN_DIR_OFS:
        begin
          ctrl_next.pin_dir  = BUS.wdata[adc_pkg::PIN_DIR_BIT];
          ctrl_next.mute_fwd = BUS.wdata[adc_pkg::MUTE_FWD_BIT];
        end
        default: ctrl_next = ctrl_reg;
      endcase
    end
  end

  // Only named fields are stored, so reserved bits read zero.
  always_comb
  begin
    rdata_next = 8'h00;
    case (BUS.addr)
      adc_pkg::POWER_CTRL_OFS:
      begin
        rdata_next[adc_pkg::POWERDOWN_BIT] = ctrl_reg.powerdown;
        rdata_next[adc_pkg::STANDBY_BIT]   = ctrl_reg.standby;
      end
      adc_pkg::MUTE_REQ_OFS:
      begin
        rdata_next[adc_pkg::LEFT_MUTE_BIT]  = ctrl_reg.left_mute;
        rdata_next[adc_pkg::RIGHT_MUTE_BIT] = ctrl_reg.right_mute;
      end
      adc_pkg::PLL_CTRL_OFS:
      begin
        rdata_next[adc_pkg::PLL_ENABLE_BIT] = ctrl_reg.pll_enable;
        rdata_next[adc_pkg::PLL_UNLOCK_BIT] = !(ctrl_reg.pll_enable && PLL_LOCKED);
      end
      adc_pkg::PAGE_INC_OFS:
        rdata_next[adc_pkg::PAGE_INC_BIT] = ctrl_reg.page_inc_dis;
      adc_pkg::FILT_OUT_OFS:
      begin
        rdata_next[adc_pkg::DEEMPH_BIT]     = ctrl_reg.deemph;
        rdata_next[adc_pkg::SOURCE_SEL_BIT] = ctrl_reg.source_sel;
      end
      adc_pkg::PIN_DIR_OFS:
      begin
        rdata_next[adc_pkg::PIN_DIR_BIT]  = ctrl_reg.pin_dir;
        rdata_next[adc_pkg::MUTE_FWD_BIT] = ctrl_reg.mute_fwd;
      end
      default: rdata_next = 8'h00;
    endcase
    if (!BUS.rd)
      rdata_next = rdata_reg;
  end

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ctrl_reg.powerdown    <= adc_pkg::POWERDOWN_RST;
      ctrl_reg.standby      <= adc_pkg::STANDBY_RST;
      ctrl_reg.left_mute    <= adc_pkg::MUTE_RST;
      ctrl_reg.right_mute   <= adc_pkg::MUTE_RST;
      ctrl_reg.pll_enable   <= adc_pkg::PLL_ENABLE_RST;
      ctrl_reg.page_inc_dis <= adc_pkg::PAGE_INC_RST;
      ctrl_reg.deemph       <= adc_pkg::DEEMPH_RST;
      ctrl_reg.source_sel   <= adc_pkg::SOURCE_SEL_RST;
      ctrl_reg.pin_dir      <= adc_pkg::PIN_DIR_RST;
      ctrl_reg.mute_fwd     <= adc_pkg::MUTE_FWD_RST;
      rdata_reg             <= 8'h00;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  assign RDATA = rdata_reg;

  // ========================================================================
  // Power state
  adc_pkg::adc_power_type pwr_reg;
  adc_pkg::adc_power_type pwr_next;

  always_comb
  begin
    if (ctrl_reg.powerdown)
      pwr_next = adc_pkg::PWR_DOWN;
    else if (ctrl_reg.standby)
      pwr_next = adc_pkg::PWR_STANDBY;
    else
      pwr_next = adc_pkg::PWR_RUN;
  end

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      pwr_reg <= adc_pkg::PWR_RUN;
    else
      pwr_reg <= pwr_next;
  end

  always_comb
  begin
    case (pwr_reg)
      adc_pkg::PWR_DOWN:
      begin
        POWERDOWN = 1'b1;
        STANDBY   = 1'b0;
        PUMP_ON   = 1'b0;
        ANALOG_ON = 1'b0;
      end
      adc_pkg::PWR_STANDBY:
      begin
        POWERDOWN = 1'b0;
        STANDBY   = 1'b1;
        PUMP_ON   = 1'b1;
        ANALOG_ON = 1'b0;
      end
      default:
      begin
        POWERDOWN = 1'b0;
        STANDBY   = 1'b0;
        PUMP_ON   = 1'b1;
        ANALOG_ON = 1'b1;
      end
    endcase
  end

  // ========================================================================
  // Soft mute ramps
  // One step per tick keeps the gain change below audible click level.
  localparam logic [VOL_W-1:0] VOL_FULL = {VOL_W{1'b1}};
  localparam int               TICK_W   = $clog2(adc_pkg::RAMP_STEP_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(adc_pkg::RAMP_STEP_CYCLES - 1);

  logic [TICK_W-1:0] tick_reg;
  logic [TICK_W-1:0] tick_next;
  logic [VOL_W-1:0]  vol_l_reg;
  logic [VOL_W-1:0]  vol_l_next;
  logic [VOL_W-1:0]  vol_r_reg;
  logic [VOL_W-1:0]  vol_r_next;
  logic              tick;

  always_comb
  begin
    tick       = (tick_reg == TICK_LAST);
    tick_next  = tick ? '0 : tick_reg + 1'b1;
    vol_l_next = vol_l_reg;
    vol_r_next = vol_r_reg;
    if (tick)
    begin
      if (ctrl_reg.left_mute && vol_l_reg != '0)
        vol_l_next = vol_l_reg - 1'b1;
      else if (!ctrl_reg.left_mute && vol_l_reg != VOL_FULL)
        vol_l_next = vol_l_reg + 1'b1;
      if (ctrl_reg.right_mute && vol_r_reg != '0)
        vol_r_next = vol_r_reg - 1'b1;
      else if (!ctrl_reg.right_mute && vol_r_reg != VOL_FULL)
        vol_r_next = vol_r_reg + 1'b1;
    end
  end

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      tick_reg  <= '0;
      vol_l_reg <= VOL_FULL;
      vol_r_reg <= VOL_FULL;
    end
    else
    begin
      tick_reg  <= tick_next;
      vol_l_reg <= vol_l_next;
      vol_r_reg <= vol_r_next;
    end
  end

  assign VOL_LEFT  = vol_l_reg;
  assign VOL_RIGHT = vol_r_reg;

  // ========================================================================
  // Clock, filter, pins and page addressing
  assign PLL_ON       = ctrl_reg.pll_enable;
  assign CLK_FROM_PIN = !ctrl_reg.pll_enable;
  assign DEEMPH_ON    = ctrl_reg.deemph;
  assign SERIAL_DATA_OUTPUT_PIN_OE = ctrl_reg.pin_dir;
  assign SERIAL_DATA_OUTPUT_PIN_IN = ctrl_reg.pin_dir ? 1'b0 : SERIAL_DATA_OUTPUT_PIN_I;
  assign AMP_MUTE     = ctrl_reg.mute_fwd && MUTE_CTRL;

  logic ser_out_reg;
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      ser_out_reg <= 1'b0;
    else
      ser_out_reg <= ctrl_reg.source_sel ? PRE_AUDIO : POST_AUDIO;
  end
  assign SERIAL_DATA_OUTPUT_PIN_O = ser_out_reg;

  always_comb
  begin
    NEXT_PAGE = PAGE;
    NEXT_ADDR = ADDR_CUR + 8'h01;
    if (ADDR_CUR == adc_pkg::PAGE_LAST_LOC)
    begin
      if (BOOK != 8'h00 && !ctrl_reg.page_inc_dis)
      begin
        NEXT_PAGE = PAGE + 8'h01;
        NEXT_ADDR = adc_pkg::NEXT_PAGE_START;
      end
      else
        NEXT_ADDR = 8'h00;
    end
  end

  // ========================================================================
  // Checks
  pd_wins_a: assert property (@(posedge MCLK) disable iff (!NRST)
    ctrl_reg.powerdown |=> POWERDOWN && !STANDBY && !PUMP_ON)
    else $error("powerdown not taken");
  pd_state_a: assert property (@(posedge MCLK) disable iff (!NRST)
    POWERDOWN |-> !PUMP_ON && !ANALOG_ON)
    else $error("pump on in powerdown");
  stby_pump_a: assert property (@(posedge MCLK) disable iff (!NRST)
    (ctrl_reg.standby && !ctrl_reg.powerdown) |=> STANDBY && PUMP_ON)
    else $error("standby wrong");
  left_ramp_a: assert property (@(posedge MCLK) disable iff (!NRST)
    (ctrl_reg.left_mute && $past(ctrl_reg.left_mute)) |-> VOL_LEFT <= $past(VOL_LEFT))
    else $error("left rose under mute");
  right_ramp_a: assert property (@(posedge MCLK) disable iff (!NRST)
    (!ctrl_reg.right_mute && $past(!ctrl_reg.right_mute)) |-> VOL_RIGHT >= $past(VOL_RIGHT))
    else $error("right fell unmuted");
  unlock_flag_a: assert property (@(posedge MCLK) disable iff (!NRST)
    (BUS.rd && BUS.addr == adc_pkg::PLL_CTRL_OFS && !ctrl_reg.pll_enable)
    |=> RDATA[adc_pkg::PLL_UNLOCK_BIT])
    else $error("unlock flag clear while disabled");
  clk_sel_a: assert property (@(posedge MCLK) disable iff (!NRST)
    (BUS.wr && BUS.addr == adc_pkg::PLL_CTRL_OFS)
    |=> PLL_ON == $past(BUS.wdata[adc_pkg::PLL_ENABLE_BIT]) && CLK_FROM_PIN != PLL_ON)
    else $error("clock select inconsistent");
  ser_out_src_a: assert property (@(posedge MCLK) disable iff (!NRST)
    ##1 SERIAL_DATA_OUTPUT_PIN_O
        == ($past(ctrl_reg.source_sel) ? $past(PRE_AUDIO) : $past(POST_AUDIO)))
    else $error("serial output source wrong");
  page_wrap_a: assert property (@(posedge MCLK) disable iff (!NRST)
    (ADDR_CUR == adc_pkg::PAGE_LAST_LOC && ctrl_reg.page_inc_dis)
    |-> NEXT_ADDR == 8'h00 && NEXT_PAGE == PAGE)
    else $error("page wrap wrong");
  fwd_mute_a: assert property (@(posedge MCLK) disable iff (!NRST)
    (BUS.wr && BUS.addr == adc_pkg::PIN_DIR_OFS) |=> (AMP_MUTE == (MUTE_CTRL
    && $past(BUS.wdata[adc_pkg::MUTE_FWD_BIT]))) && (SERIAL_DATA_OUTPUT_PIN_OE
    == $past(BUS.wdata[adc_pkg::PIN_DIR_BIT])))
    else $error("forwarding or pin direction wrong");
  rsvd_zero_a: assert property (@(posedge MCLK) disable iff (!NRST)
    (BUS.rd && BUS.addr == adc_pkg::MUTE_REQ_OFS) |=> RDATA[7:5] == 3'h0)
    else $error("reserved bits set");

  pd_seen_c:   cover property (@(posedge MCLK) disable iff (!NRST) POWERDOWN);
  stby_seen_c: cover property (@(posedge MCLK) disable iff (!NRST) STANDBY);
  mute_done_c: cover property (@(posedge MCLK) disable iff (!NRST) VOL_LEFT == '0);
  page_next_c: cover property (@(posedge MCLK) disable iff (!NRST)
    NEXT_ADDR == adc_pkg::NEXT_PAGE_START && NEXT_PAGE != PAGE);

endmodule : adc_ctrl_regs

/* sim/audio_dac_control_registers_tb_top.sv */
`timescale 1ns/1ps
module audio_dac_control_registers_tb_top;
  // ==========================================================================
  // Signals and expectation queue.
  typedef struct {
    int          sel;
    logic [15:0] exp;
    string       what;
  } adc_note_type;

  localparam logic [7:0] OFS   [7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
  localparam logic [7:0] RST_V [7] = '{8'h00, 8'h00, 8'h11, 8'h00, 8'h00, 8'h01, 8'h00};
  localparam logic [7:0] FULL_V[7] = '{8'h11, 8'h11, 8'h01, 8'h00, 8'h08, 8'h11, 8'h30};
  localparam logic [7:0] PW    [4] = '{8'h01, 8'h10, 8'h11, 8'h00};
  localparam logic [3:0] PW_E  [4] = '{4'b1000, 4'b0110, 4'b1000, 4'b0011};

  logic                 mclk;
  logic                 nrst;
  adc_pkg::adc_bus_type bus;
  logic [7:0]           rdata, book, page, addr_cur, next_page, next_addr, vol_l, vol_r;
  logic                 pll_locked, pre_a, post_a, sd_i, mute_c, probe;
  logic                 pd, sb, pump, ana, pll_on, from_pin, deemph, sd_o, sd_oe, sd_in, amp;
  logic                 rd_q = 1'b0;
  logic [31:0]          lfsr = 32'h08e5;
  int                   errors, compares;
  adc_note_type         notes[$];
  adc_note_type         n;

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  adc_ctrl_regs #(.VOL_W(8)) dut_u (
    .MCLK(mclk), .NRST(nrst), .BUS(bus), .RDATA(rdata), .PLL_LOCKED(pll_locked),
    .BOOK(book), .PAGE(page), .ADDR_CUR(addr_cur), .NEXT_PAGE(next_page),
    .NEXT_ADDR(next_addr), .POWERDOWN(pd), .STANDBY(sb), .PUMP_ON(pump),
    .ANALOG_ON(ana), .VOL_LEFT(vol_l), .VOL_RIGHT(vol_r), .PLL_ON(pll_on),
    .CLK_FROM_PIN(from_pin), .DEEMPH_ON(deemph), .PRE_AUDIO(pre_a), .POST_AUDIO(post_a),
    .SERIAL_DATA_OUTPUT_PIN_I(sd_i), .SERIAL_DATA_OUTPUT_PIN_O(sd_o),
    .SERIAL_DATA_OUTPUT_PIN_OE(sd_oe), .SERIAL_DATA_OUTPUT_PIN_IN(sd_in),
    .MUTE_CTRL(mute_c), .AMP_MUTE(amp)
  );

  // ==========================================================================
  // Shared helpers.
  function automatic logic [31:0] step(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : step

  function automatic logic [15:0] observe(int s);
    case (s)
      0: return {8'h00, rdata};
      1: return {12'h000, pd, sb, pump, ana};
      2: return {vol_l, vol_r};
      3: return {9'h000, pll_on, from_pin, deemph, sd_oe, sd_in, amp, sd_o};
      default: return {next_page, next_addr};
    endcase
  endfunction : observe

  task automatic compare(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : compare

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic cyc(int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc

  // Each bus task idles one cycle at its end so that strobes never toggle twice at once.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    bus = '{1'b1, 1'b0, a, d};
    cyc(1);
    bus = '0;
    cyc(1);
  endtask : wr

  task automatic rd(logic [7:0] a, logic [7:0] e, string what);
    notes.push_back('{0, {8'h00, e}, what});
    bus = '{1'b0, 1'b1, a, 8'h00};
    cyc(1);
    bus = '0;
    cyc(1);
  endtask : rd

  task automatic expect_out(int s, logic [15:0] e, string what);
    cyc(2);
    notes.push_back('{s, e, what});
    probe = 1'b1;
    cyc(1);
    probe = 1'b0;
  endtask : expect_out

  // The volume may move by one step per cycle at most, which is what keeps the ramp silent.
  task automatic ramp(bit left, logic [7:0] target);
    int         k;
    logic [7:0] v, p;
    k = 0;
    p = left ? vol_l : vol_r;
    v = p;
    while (k < 3000 && v !== target)
    begin
      cyc(1);
      k++;
      v = left ? vol_l : vol_r;
      if (v > p + 1 || p > v + 1)
        compare("ramp step", {8'h00, p}, {8'h00, v});
      p = v;
    end
    if (k >= 3000)
    begin
      compare("ramp timeout", 16'h0000, 16'h0001);
      tally_and_finish();
    end
    compare("ramp duration", 16'h0001, {15'h0000, k >= 2530 && k <= 2570});
    expect_out(2, left ? {target, 8'hff} : {8'hff, target}, "volumes");
  endtask : ramp

  // ==========================================================================
  // Result watcher: every read or probe consumes the oldest note.
  always @(posedge mclk) rd_q <= bus.rd;

  always @(negedge mclk)
  begin
    if (rd_q || probe)
    begin
      if (notes.size() == 0)
        compare("unexpected result", 16'h0000, 16'hffff);
      else
      begin
        n = notes.pop_front();
        compare(n.what, n.exp, observe(n.sel));
      end
    end
  end

  // ==========================================================================
  // Main sequence.
  initial
  begin
    int         i;
    logic [7:0] r;
    {nrst, book, page, addr_cur, pll_locked, pre_a, post_a, sd_i, mute_c, probe} = '0;
    bus = '0;
    errors = 0;
    compares = 0;
    cyc(2);
    nrst = 1'b1;
    cyc(1);
    for (i = 0; i < 7; i++)
      rd(OFS[i], RST_V[i], "reset value");
    expect_out(1, 16'h0003, "power state");
    expect_out(2, 16'hffff, "volumes");
    expect_out(3, 16'h0040, "pin outputs");
    $display("test reset done");
    pll_locked = 1'b1;
    for (i = 0; i < 7; i++)
    begin
      wr(OFS[i], 8'hff);
      rd(OFS[i], FULL_V[i], "written value");
      wr(OFS[i], 8'h00);
    end
    $display("test reserved done");
    for (i = 0; i < 4; i++)
    begin
      wr(8'h02, PW[i]);
      expect_out(1, {12'h000, PW_E[i]}, "power state");
    end
    $display("test power done");
    wr(8'h04, 8'h01);
    rd(8'h04, 8'h01, "lock flag");
    pll_locked = 1'b0;
    rd(8'h04, 8'h11, "lock flag");
    pll_locked = 1'b1;
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h10, "lock flag");
    expect_out(3, 16'h0020, "pin outputs");
    wr(8'h04, 8'h01);
    $display("test pll done");
    for (i = 0; i < 8; i++)
    begin
      lfsr = step(lfsr);
      r = lfsr[7:0];
      {pre_a, post_a, sd_i, mute_c} = lfsr[11:8];
      wr(8'h07, {3'h0, r[4], 3'h0, r[0]});
      wr(8'h08, {2'h0, r[5], r[6], 4'h0});
      expect_out(3, {9'h000, 2'b10, r[4], r[5], sd_i & ~r[5], mute_c & r[6],
                     r[0] ? pre_a : post_a}, "pin outputs");
    end
    $display("test pins done");
    for (i = 0; i < 12; i++)
    begin
      lfsr = step(lfsr);
      book = (i % 4 == 3) ? 8'h00 : (lfsr[7:0] | 8'h01);
      page = lfsr[15:8];
      addr_cur = (i % 4 == 2) ? (lfsr[23:16] & 8'h7e) : 8'h7f;
      wr(8'h06, (i % 4 == 1) ? 8'h08 : 8'h00);
      expect_out(4, (i % 4 == 0) ? {page + 8'h01, 8'h08} :
                    (i % 4 == 2) ? {page, addr_cur + 8'h01} : {page, 8'h00},
                 "next position");
    end
    $display("test page done");
    for (i = 1; i >= 0; i--)
    begin
      wr(8'h03, i ? 8'h10 : 8'h01);
      ramp(i[0], 8'h00);
      wr(8'h03, 8'h00);
      ramp(i[0], 8'hff);
    end
    $display("test mute done");
    wr(8'h04, 8'h00);
    nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    cyc(1);
    rd(8'h04, 8'h01, "pll after reset");
    $display("test second reset done");
    tally_and_finish();
  end

endmodule : audio_dac_control_registers_tb_top
